// ===== common/pmd_consts.vh
`ifndef PMD_CONSTS_VH
`define PMD_CONSTS_VH

// ****************************************************************
// register map (byte addresses on the register bus)
// ****************************************************************
`define PMD_ADDR_W        4
`define PMD_OFS_CTRL1     4'h0
`define PMD_OFS_CTRL2     4'h4
`define PMD_OFS_STATUS    4'h8

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PMD_BIT_ADC1      0
`define PMD_BIT_CAN1      1
`define PMD_BIT_CAN2      2
`define PMD_CTRL1_MASK    16'h0007
`define PMD_CAP_LSB       8
`define PMD_CMP_LSB       0
`define PMD_UNIT_CNT      8
`define PMD_CTRL1_RST     16'h0000
`define PMD_CTRL2_RST     16'h0000

// ****************************************************************
// bus answers and timing
// ****************************************************************
`define PMD_RESP_OKAY     2'h0
`define PMD_RESP_SLVERR   2'h2
`define PMD_INSTR_CYCLES  1

`endif

// ===== dv/pmd_disable_regs_bench.sv
`include "pmd_consts.vh"

// ******
// self-checking bench
// ******
module pmd_disable_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = '0;
   logic        rst = '1;
   logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
   logic [15:0] pinAnalogCfg = '0;
   wire         awready, wready, bvalid, arready, rvalid, adc1En, can1En, can2En;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  captureEn, compareEn;
   wire  [15:0] pinAnalogMode;
   int          failures = 0, num_checks = 0;

   pmd_disable_regs pmd_disable_regs_i (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .adc1En,
      .can1En, .can2En, .captureEn, .compareEn, .pinAnalogCfg, .pinAnalogMode);

   always #20 ref_clk = ~ref_clk;

   task automatic results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   // bounded wait: one cycle, sampled at the falling edge
   task automatic tick(inout int n);
      n++;
      if (n > 50) begin
         chk(1'b0, "bus timeout");
         results();
      end else begin
         @(negedge ref_clk);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      int   n = 0;
      logic aw = 1, w = 1;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw || w) begin
         tick(n);
         aw = aw && awready !== 1'b1;
         w = w && wready !== 1'b1;
         @(posedge ref_clk);
         awvalid <= aw;
         wvalid <= w;
      end
      do tick(n); while (bvalid !== 1'b1);
      chk(bresp === e, "write response");
      @(posedge ref_clk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] e);
      int n = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do tick(n); while (arready !== 1'b1);
      @(posedge ref_clk);
      arvalid <= 1'b0;
      do tick(n); while (rvalid !== 1'b1);
      chk(rdata === x && rresp === e, "read data or response");
      @(posedge ref_clk);
      rready <= 1'b0;
   endtask

   task automatic t_reset();
      chk({adc1En, can1En, can2En, captureEn, compareEn} === 19'h7FFFF, "enables after reset");
      rd(`PMD_OFS_CTRL1, 32'h0, `PMD_RESP_OKAY);
      rd(`PMD_OFS_CTRL2, 32'h0, `PMD_RESP_OKAY);
      $display("test reset done");
   endtask

   task automatic t_ctrl1();
      for (int i = 0; i < 3; i++) begin
         wr(`PMD_OFS_CTRL1, 32'h1 << i, 4'hF, `PMD_RESP_OKAY);
         cyc(3);
         chk({can2En, can1En, adc1En} === ~(3'h1 << i), "ctrl1 gating");
      end
      wr(`PMD_OFS_CTRL1, 32'hFFFFFFFF, 4'hF, `PMD_RESP_OKAY);
      rd(`PMD_OFS_CTRL1, {16'h0, `PMD_CTRL1_MASK}, `PMD_RESP_OKAY);
      @(posedge ref_clk);
      pinAnalogCfg <= 16'hA5C3;
      cyc(3);
      chk(pinAnalogMode === 16'h0, "pins digital while converter off");
      wr(`PMD_OFS_CTRL1, 32'h0, 4'hF, `PMD_RESP_OKAY);
      cyc(3);
      chk(pinAnalogMode === 16'hA5C3 && {adc1En, can1En, can2En} === 3'h7, "re-enable");
      $display("test ctrl1 done");
   endtask

   task automatic t_ctrl2();
      wr(`PMD_OFS_CTRL2, 32'h0000A55A, 4'h3, `PMD_RESP_OKAY);
      cyc(3);
      chk(captureEn === 8'h5A && compareEn === 8'hA5, "ctrl2 gating");
      wr(`PMD_OFS_CTRL2, 32'h00003C00, 4'h2, `PMD_RESP_OKAY);
      cyc(3);
      chk(captureEn === 8'hC3 && compareEn === 8'hA5, "upper lane only");
      rd(`PMD_OFS_CTRL2, 32'h00003C5A, `PMD_RESP_OKAY);
      $display("test ctrl2 done");
   endtask

   task automatic t_map();
      wr(`PMD_OFS_CTRL1, 32'h5, 4'hF, `PMD_RESP_OKAY);
      @(negedge ref_clk);
      chk({adc1En, can1En, can2En} === 3'h7, "enables changed too early");
      @(negedge ref_clk);
      chk({adc1En, can1En, can2En} === 3'h2, "enables not in force in time");
      rd(`PMD_OFS_STATUS, 32'h00053C5A, `PMD_RESP_OKAY);
      wr(`PMD_OFS_STATUS, 32'h0, 4'hF, `PMD_RESP_OKAY);
      rd(`PMD_OFS_STATUS, 32'h00053C5A, `PMD_RESP_OKAY);
      wr(4'hC, 32'h2, 4'hF, `PMD_RESP_SLVERR);
      rd(4'hC, 32'h0, `PMD_RESP_SLVERR);
      rd(`PMD_OFS_CTRL1, 32'h5, `PMD_RESP_OKAY);
      wr(`PMD_OFS_CTRL2, 32'h0, 4'h3, `PMD_RESP_OKAY);
      cyc(3);
      chk(captureEn === 8'hFF && compareEn === 8'hFF && !adc1En && can1En && !can2En, "final state");
      $display("test map done");
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      t_reset();
      t_ctrl1();
      t_ctrl2();
      t_map();
      results();
   end
endmodule

// ===== dv/pmd_disable_regs_chk.sv
`include "pmd_consts.vh"

// ******
// checker on the register bank ports
// ******
module pmd_disable_regs_chk #(
   parameter NPIN  = 16,
   parameter NUNIT = 8
) (
   // clock and reset
   input logic             ref_clk,
   input logic             rst,
   // write request
   input logic [3:0]       awaddr,
   input logic             awvalid,
   input logic             awready,
   input logic [31:0]      wdata,
   input logic [3:0]       wstrb,
   input logic             wvalid,
   input logic             wready,
   // enables and pins
   input logic             adc1En,
   input logic             can1En,
   input logic             can2En,
   input logic [NUNIT-1:0] captureEn,
   input logic [NUNIT-1:0] compareEn,
   input logic [NPIN-1:0]  pinAnalogCfg,
   input logic [NPIN-1:0]  pinAnalogMode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire wrHit = awvalid && awready && wvalid && wready;
   wire wr1   = wrHit && awaddr == `PMD_OFS_CTRL1 && wstrb[0];
   wire wr2   = wrHit && awaddr == `PMD_OFS_CTRL2;
   a_adc_gate: assert property (wr1 |=> ##2 adc1En == !$past(wdata[0], 3))
      else $error("converter enable wrong");
   a_can1_gate: assert property (wr1 |=> ##2 can1En == !$past(wdata[1], 3))
      else $error("first can enable wrong");
   a_can2_gate: assert property (wr1 |=> ##2 can2En == !$past(wdata[2], 3))
      else $error("second can enable wrong");
   a_capture_gate: assert property (wr2 && wstrb[1] |=> ##2 captureEn == ~$past(wdata[15:8], 3))
      else $error("capture enables wrong");
   a_compare_gate: assert property (wr2 && wstrb[0] |=> ##2 compareEn == ~$past(wdata[7:0], 3))
      else $error("compare enables wrong");
   a_pins_digital: assert property (pinAnalogMode == (adc1En ? pinAnalogCfg : '0))
      else $error("pin mode wrong");
   a_hold_early: assert property (wrHit && !$past(wrHit) && !$past(wrHit, 2) |=> $stable({adc1En, can1En, can2En}) ##1 $stable({adc1En, can1En, can2En}))
      else $error("enable changed too early");
   c_wr1: cover property (wr1 && wdata[0]);
   c_wr2: cover property (wr2 && wstrb[1]);
   c_off: cover property (!adc1En && |pinAnalogCfg);
endmodule

bind pmd_disable_regs pmd_disable_regs_chk #(.NPIN(NPIN), .NUNIT(NUNIT)) pmd_disable_regs_chk_i (.ref_clk, .rst,
   .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .adc1En, .can1En, .can2En, .captureEn,
   .compareEn, .pinAnalogCfg, .pinAnalogMode);

// ===== hdl/pmd_axil_slave.v
`include "pmd_consts.vh"

// ****************************************************************
// axi4-lite slave: one write and one read at a time
// ****************************************************************
module pmd_axil_slave #(
   parameter AW = `PMD_ADDR_W
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          rst,
   // write address and data
   input  wire [AW-1:0] awaddr,
   input  wire          awvalid,
   output wire          awready,
   input  wire [31:0]   wdata,
   input  wire [3:0]    wstrb,
   input  wire          wvalid,
   output wire          wready,
   // write response
   output reg  [1:0]    bresp,
   output reg           bvalid,
   input  wire          bready,
   // read address and data
   input  wire [AW-1:0] araddr,
   input  wire          arvalid,
   output wire          arready,
   output reg  [31:0]   rdata,
   output reg  [1:0]    rresp,
   output reg           rvalid,
   input  wire          rready,
   // register side
   output wire          wrStb,
   output wire [AW-1:0] wrAddr,
   output wire [31:0]   wrData,
   output wire [3:0]    wrStrb,
   output wire [AW-1:0] rdAddr,
   input  wire [31:0]   rdData,
   input  wire          rdOk,
   input  wire          wrOk
);

   reg          awHeld_ff;
   reg [AW-1:0] awAddr_ff;
   reg          wHeld_ff;
   reg [31:0]   wData_ff;
   reg [3:0]    wStrb_ff;

   assign awready = !awHeld_ff && !bvalid;
   assign wready  = !wHeld_ff && !bvalid;
   assign arready = !rvalid;

   // write fires when both halves are present, held or arriving now
   wire          haveAw = awHeld_ff || (awvalid && awready);
   wire          haveW  = wHeld_ff || (wvalid && wready);
   assign wrStb  = haveAw && haveW && !bvalid;
   assign wrAddr = awHeld_ff ? awAddr_ff : awaddr;
   assign wrData = wHeld_ff ? wData_ff : wdata;
   assign wrStrb = wHeld_ff ? wStrb_ff : wstrb;
   assign rdAddr = araddr;

   always @(posedge ref_clk) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= {AW{1'b0}};
         wHeld_ff  <= 1'b0;
         wData_ff  <= 32'h00000000;
         wStrb_ff  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `PMD_RESP_OKAY;
      end else begin
         if (wrStb) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= wrOk ? `PMD_RESP_OKAY : `PMD_RESP_SLVERR;
         end else begin
            if (awvalid && awready) begin
               awHeld_ff <= 1'b1;
               awAddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
               wHeld_ff <= 1'b1;
               wData_ff <= wdata;
               wStrb_ff <= wstrb;
            end
            if (bvalid && bready) begin
               bvalid <= 1'b0;
            end
         end
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `PMD_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rdOk ? rdData : 32'h00000000;
         rresp  <= rdOk ? `PMD_RESP_OKAY : `PMD_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule

// ===== hdl/pmd_disable_regs.v
// Local design decisions: the AXI4-Lite register port and the register addresses.
`include "pmd_consts.vh"

// ****************************************************************
// peripheral disable register bank
// ****************************************************************
// Summary of operation
// - bit 0 of ctrl1 disables first converter
// - converter off forces analog pins digital
// - bit 2 of ctrl1 disables second CAN
// - bit 1 of ctrl1 disables first CAN
// - ctrl2 bits 15..8 disable capture 8..1
// - disable changes act IDELAY plus one clock cycles after the write edge
module pmd_disable_regs #(
   parameter NPIN   = 16,
   parameter NUNIT  = `PMD_UNIT_CNT,
   parameter IDELAY = `PMD_INSTR_CYCLES
) (
   // clock and reset
   input  wire                   ref_clk,
   input  wire                   rst,
   // axi4-lite write address
   input  wire [`PMD_ADDR_W-1:0] awaddr,
   input  wire                   awvalid,
   output wire                   awready,
   // axi4-lite write data
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output wire                   wready,
   // axi4-lite write response
   output wire [1:0]             bresp,
   output wire                   bvalid,
   input  wire                   bready,
   // axi4-lite read address
   input  wire [`PMD_ADDR_W-1:0] araddr,
   input  wire                   arvalid,
   output wire                   arready,
   // axi4-lite read data
   output wire [31:0]            rdata,
   output wire [1:0]             rresp,
   output wire                   rvalid,
   input  wire                   rready,
   // peripheral enables, high = running
   output wire                   adc1En,
   output wire                   can1En,
   output wire                   can2En,
   output wire [NUNIT-1:0]       captureEn,
   output wire [NUNIT-1:0]       compareEn,
   // pins shared with analog inputs
   input  wire [NPIN-1:0]        pinAnalogCfg,
   output wire [NPIN-1:0]        pinAnalogMode
);

   // ****************************************************************
   // registers
   // ****************************************************************
   reg  [15:0]            ctrl1_ff;
   reg  [15:0]            ctrl2_ff;
   reg  [15:0]            nxt_ctrl1;
   reg  [15:0]            nxt_ctrl2;
   reg  [15:0]            eff1_ff [0:IDELAY];
   reg  [15:0]            eff2_ff [0:IDELAY];
   wire                   wrStb;
   wire [`PMD_ADDR_W-1:0] wrAddr;
   wire [31:0]            wrData;
   wire [3:0]             wrStrb;
   wire [`PMD_ADDR_W-1:0] rdAddr;
   reg  [31:0]            rdData;
   reg                    rdOk;
   reg                    wrOk;

   pmd_axil_slave #(.AW(`PMD_ADDR_W)) uBus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrStb   (wrStb),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdOk    (rdOk),
      .wrOk    (wrOk)
   );

   // ****************************************************************
   // write decode with byte lanes
   // ****************************************************************
   always @* begin
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      wrOk      = 1'b1;
      case (wrAddr)
         `PMD_OFS_CTRL1: begin
            if (wrStb && wrStrb[0]) begin
               nxt_ctrl1 = {8'h00, wrData[7:0]} & `PMD_CTRL1_MASK;
            end
         end
         `PMD_OFS_CTRL2: begin
            if (wrStb && wrStrb[0]) begin
               nxt_ctrl2[7:0] = wrData[7:0];
            end
            if (wrStb && wrStrb[1]) begin
               nxt_ctrl2[15:8] = wrData[15:8];
            end
         end
         `PMD_OFS_STATUS: begin
            wrOk = 1'b1;
         end
         default: begin
            wrOk = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         ctrl1_ff <= `PMD_CTRL1_RST;
         ctrl2_ff <= `PMD_CTRL2_RST;
      end else begin
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
      end
   end

   // ****************************************************************
   // effect delay: register value reaches peripherals later
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         eff1_ff[0] <= `PMD_CTRL1_RST;
         eff2_ff[0] <= `PMD_CTRL2_RST;
      end else begin
         eff1_ff[0] <= ctrl1_ff;
         eff2_ff[0] <= ctrl2_ff;
      end
   end

   genvar s;
   generate
      for (s = 1; s <= IDELAY; s = s + 1) begin : gDly
         always @(posedge ref_clk) begin
            if (rst) begin
               eff1_ff[s] <= `PMD_CTRL1_RST;
               eff2_ff[s] <= `PMD_CTRL2_RST;
            end else begin
               eff1_ff[s] <= eff1_ff[s-1];
               eff2_ff[s] <= eff2_ff[s-1];
            end
         end
      end
   endgenerate

   // last stage drives the peripherals: write edge plus IDELAY plus one
   wire [15:0] eff1 = eff1_ff[IDELAY];
   wire [15:0] eff2 = eff2_ff[IDELAY];

   // ****************************************************************
   // peripheral enables
   // ****************************************************************
   assign adc1En = !eff1[`PMD_BIT_ADC1];
   assign can1En = !eff1[`PMD_BIT_CAN1];
   assign can2En = !eff1[`PMD_BIT_CAN2];

   genvar u;
   generate
      for (u = 0; u < NUNIT; u = u + 1) begin : gUnit
         assign captureEn[u] = !eff2[`PMD_CAP_LSB+u];
         assign compareEn[u] = !eff2[`PMD_CMP_LSB+u];
      end
   endgenerate

   pmd_pin_mode #(.NPIN(NPIN)) uPins (
      .adc1Off       (eff1[`PMD_BIT_ADC1]),
      .pinAnalogCfg  (pinAnalogCfg),
      .pinAnalogMode (pinAnalogMode)
   );

   // ****************************************************************
   // read decode; status shows the disable bits in force
   // ****************************************************************
   always @* begin
      rdData = 32'h00000000;
      rdOk   = 1'b1;
      case (rdAddr)
         `PMD_OFS_CTRL1: begin
            rdData = {16'h0000, ctrl1_ff};
         end
         `PMD_OFS_CTRL2: begin
            rdData = {16'h0000, ctrl2_ff};
         end
         `PMD_OFS_STATUS: begin
            rdData = {13'h0000, eff1[2:0], eff2};
         end
         default: begin
            rdOk = 1'b0;
         end
      endcase
   end

endmodule

// ===== hdl/pmd_pin_mode.v
`include "pmd_consts.vh"

// ****************************************************************
// analog/digital selection of pins shared with analog inputs
// ****************************************************************
module pmd_pin_mode #(
   parameter NPIN = 16
) (
   // control
   input  wire            adc1Off,
   input  wire [NPIN-1:0] pinAnalogCfg,
   // result: one = pin in analog mode
   output wire [NPIN-1:0] pinAnalogMode
);

   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : gPin
         // configuration ignored while the converter is off
         assign pinAnalogMode[i] = pinAnalogCfg[i] && !adc1Off;
      end
   endgenerate

endmodule
